// ===== lsppc_pkg.sv
// Constants, types and TAP decoding shared by both link ends.
// Assumes one backplane TAP link clocked by a slow test clock.
package lsppc_pkg;

  localparam int NPORT = 7;
  localparam int IRW   = 8;

  // Instruction opcodes and the Capture-IR pattern
  localparam logic [7:0] OP_PARK_IDLE  = 8'h84;
  localparam logic [7:0] OP_PARK_PAUSE = 8'hc6;
  localparam logic [7:0] OP_RET_WAIT   = 8'hc3;
  localparam logic [7:0] OP_UNPARK     = 8'he7;
  localparam logic [7:0] OP_BYPASS     = 8'hff;
  localparam logic [7:0] IR_CAPTURE    = 8'h01;
  // Broadcast slot address, value arbitrary
  localparam logic [7:0] ADDR_BCAST    = 8'h3a;

  // Link clock made by the host: period in ns, half period in clk cycles
  localparam int CLK_NS   = 100;
  localparam int LINK_NS  = 800;
  localparam int TCK_HALF = LINK_NS / (2 * CLK_NS);
  localparam logic [2:0] CNT_RISE = 3'(TCK_HALF - 1);
  localparam logic [2:0] CNT_FALL = 3'(2 * TCK_HALF - 1);

  typedef enum logic [3:0] {
    TAP_EX2_DR = 4'h0, TAP_EX1_DR = 4'h1, TAP_SH_DR  = 4'h2,
    TAP_PAU_DR = 4'h3, TAP_SEL_IR = 4'h4, TAP_UPD_DR = 4'h5,
    TAP_CAP_DR = 4'h6, TAP_SEL_DR = 4'h7, TAP_EX2_IR = 4'h8,
    TAP_EX1_IR = 4'h9, TAP_SH_IR  = 4'ha, TAP_PAU_IR = 4'hb,
    TAP_RTI    = 4'hc, TAP_UPD_IR = 4'hd, TAP_CAP_IR = 4'he,
    TAP_TLR    = 4'hf
  } lsppc_tap_e;

  typedef enum logic [1:0] {
    SEL_WAIT   = 2'h0,
    SEL_SINGLE = 2'h1,
    SEL_BCAST  = 2'h3,
    SEL_UNSEL  = 2'h2
  } lsppc_sel_e;

  function automatic lsppc_tap_e tap_next(input lsppc_tap_e s,
                                          input logic       tms);
    case (s)
      TAP_TLR:    tap_next = tms ? TAP_TLR    : TAP_RTI;
      TAP_RTI:    tap_next = tms ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_DR: tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tap_next = tms ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: tap_next = tms ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: tap_next = tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: tap_next = tms ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_IR: tap_next = tms ? TAP_TLR    : TAP_CAP_IR;
      TAP_CAP_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tap_next = tms ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: tap_next = tms ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: tap_next = tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: tap_next = tms ? TAP_SEL_DR : TAP_RTI;
      default:    tap_next = TAP_TLR;
    endcase
  endfunction : tap_next

  function automatic logic is_ir(input lsppc_tap_e s);
    case (s)
      TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR,
      TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR: is_ir = 1'b1;
      default:                            is_ir = 1'b0;
    endcase
  endfunction : is_ir

endpackage : lsppc_pkg

// ===== lsppc_link_if.sv
// Backplane test access link between the scan controller and the bridge.
// Assumes a pull-up on the returned data line when the bridge releases it.
`timescale 1ns/1ps
interface lsppc_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe_n;
  logic tdo_line;

  // Released line reads high
  assign tdo_line = tdo_oe_n ? 1'b1 : tdo;

  modport host (output tck, output tms, output tdi, input tdo_line);
  modport dev  (input tck, input tms, input tdi,
                output tdo, output tdo_oe_n);
endinterface : lsppc_link_if

// ===== lsppc_tap.sv
// TAP controller state tracker, advanced by a one-cycle step pulse.
// Assumes tms is stable in the cycle that adv is high.
`timescale 1ns/1ps
module lsppc_tap (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic                 adv,
  input  wire logic                 tms,
  output lsppc_pkg::lsppc_tap_e     state,
  output lsppc_pkg::lsppc_tap_e     nxt
);
  lsppc_pkg::lsppc_tap_e state_q;

  assign nxt   = lsppc_pkg::tap_next(state_q, tms);
  assign state = state_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= lsppc_pkg::TAP_TLR;
    end else if (adv) begin
      state_q <= nxt;
    end
  end
endmodule : lsppc_tap

// ===== lsppc_dev.sv
// Bridge end: local scan port park and unpark control.
// Assumes the backplane link pins are asynchronous to clk and the test
// clock is at most an eighth of clk; local port pins likewise.
// Operation
// - Unparked ports follow backplane mode-select
// - Park-in-idle update forces local mode-select low
// - Controller drives mode-select low after park-in-idle
// - Parked ports leave the active scan path
// - Park-in-pause arms; parks on Exit1-to-Update
// - Armed, Exit1 and mode-select high forces zero
// - Passing Pause-DR leaves armed ports unparked
// - Pause-parked ports hold through later instructions
// - Stay parked until park-in-pause or unpark loads
// - Unpark when the matching Pause state is entered
// - Parked ports never see Capture-DR
// - Return-to-wait leaves parked ports unchanged
// - Reset waits address; match selects, others unselected
// - Set-up: preload, park, return-to-wait without Pause-IR
// - Test: broadcast, park-in-pause, IR then DR cycle
// - Readout: address each, unpark at Pause-DR, shift
// - Return-to-wait obeyed by all; others selected only
`timescale 1ns/1ps
module lsppc_dev (
  input  wire logic                         clk,
  input  wire logic                         nrst,
  lsppc_link_if.dev                         link,
  input  wire logic [7:0]                   slot_addr,
  input  wire logic [lsppc_pkg::NPORT-1:0]  port_en,
  input  wire logic [lsppc_pkg::NPORT-1:0]  ltdo,
  output logic                              ltck,
  output logic [lsppc_pkg::NPORT-1:0]       ltms,
  output logic [lsppc_pkg::NPORT-1:0]       ltdi,
  output logic [lsppc_pkg::NPORT-1:0]       parked,
  output logic [lsppc_pkg::NPORT-1:0]       parked_pause,
  output lsppc_pkg::lsppc_sel_e             sel_state
);
  localparam int NP    = lsppc_pkg::NPORT;
  localparam int SW    = NP + 3;
  localparam int B_TCK = 0;
  localparam int B_TMS = 1;
  localparam int B_TDI = 2;
  localparam int B_LDO = 3;

  // Input synchronisers: three stages, a change counts once 2 and 3 agree
  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;
  logic [SW-1:0] s3_q;
  logic [SW-1:0] st_q;
  logic          tck_prev_q;
  logic          rise;
  logic          fall;
  logic          tms_st;
  logic          tdi_st;
  logic [NP-1:0] ltdo_st;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      st_q <= '0;
    end else begin
      s1_q <= {ltdo, link.tdi, link.tms, link.tck};
      s2_q <= s1_q;
      s3_q <= s2_q;
      st_q <= (s2_q & s3_q) | (st_q & (s2_q ^ s3_q));
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      tck_prev_q <= 1'b0;
    end else begin
      tck_prev_q <= st_q[B_TCK];
    end
  end

  assign rise    = st_q[B_TCK] & ~tck_prev_q;
  assign fall    = ~st_q[B_TCK] & tck_prev_q;
  assign tms_st  = st_q[B_TMS];
  assign tdi_st  = st_q[B_TDI];
  assign ltdo_st = st_q[B_LDO +: NP];

  // Own TAP controller
  lsppc_pkg::lsppc_tap_e state;
  lsppc_pkg::lsppc_tap_e nxt;

  lsppc_tap u_tap (
    .clk   (clk),
    .nrst  (nrst),
    .adv   (rise),
    .tms   (tms_st),
    .state (state),
    .nxt   (nxt)
  );

  // Instruction shift path, active instruction and selection
  logic [lsppc_pkg::IRW-1:0] ir_sh_q;
  logic [lsppc_pkg::IRW-1:0] instr_q;
  logic                      byp_q;
  lsppc_pkg::lsppc_sel_e     sel_q;
  logic                      selected;

  assign selected  = (sel_q == lsppc_pkg::SEL_SINGLE) ||
                     (sel_q == lsppc_pkg::SEL_BCAST);
  assign sel_state = sel_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ir_sh_q <= lsppc_pkg::IR_CAPTURE;
      byp_q   <= 1'b0;
    end else if (rise) begin
      case (state)
        lsppc_pkg::TAP_CAP_IR: ir_sh_q <= lsppc_pkg::IR_CAPTURE;
        lsppc_pkg::TAP_SH_IR:  ir_sh_q <= {tdi_st, ir_sh_q[7:1]};
        lsppc_pkg::TAP_CAP_DR: byp_q   <= 1'b0;
        lsppc_pkg::TAP_SH_DR:  byp_q   <= tdi_st;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sel_q   <= lsppc_pkg::SEL_WAIT;
      instr_q <= lsppc_pkg::OP_BYPASS;
    end else if (rise) begin
      if (state == lsppc_pkg::TAP_TLR) begin
        sel_q   <= lsppc_pkg::SEL_WAIT;
        instr_q <= lsppc_pkg::OP_BYPASS;
      end else if (state == lsppc_pkg::TAP_UPD_IR) begin
        if (ir_sh_q == lsppc_pkg::OP_RET_WAIT) begin
          // Obeyed whatever the selection; ports are left alone
          sel_q   <= lsppc_pkg::SEL_WAIT;
          instr_q <= lsppc_pkg::OP_BYPASS;
        end else begin
          case (sel_q)
            lsppc_pkg::SEL_WAIT: begin
              if (ir_sh_q == slot_addr) begin
                sel_q <= lsppc_pkg::SEL_SINGLE;
              end else if (ir_sh_q == lsppc_pkg::ADDR_BCAST) begin
                sel_q <= lsppc_pkg::SEL_BCAST;
              end else begin
                sel_q <= lsppc_pkg::SEL_UNSEL;
              end
            end
            lsppc_pkg::SEL_SINGLE,
            lsppc_pkg::SEL_BCAST: instr_q <= ir_sh_q;
            default: ;
          endcase
        end
      end
    end
  end

  // Park-in-pause counts from the moment it is being loaded as well,
  // so the load's own Exit1-IR to Update-IR already parks the ports.
  logic pp_now;
  logic unpark_op;
  logic pause_park_now;
  logic idle_park_now;

  assign pp_now = (instr_q == lsppc_pkg::OP_PARK_PAUSE) ||
                  (lsppc_pkg::is_ir(state) &&
                   ir_sh_q == lsppc_pkg::OP_PARK_PAUSE);
  assign unpark_op = pp_now || (instr_q == lsppc_pkg::OP_UNPARK);
  assign pause_park_now = selected && pp_now && tms_st &&
                          (state == lsppc_pkg::TAP_EX1_DR ||
                           state == lsppc_pkg::TAP_EX1_IR);
  assign idle_park_now = selected &&
                         state == lsppc_pkg::TAP_UPD_IR &&
                         ir_sh_q == lsppc_pkg::OP_PARK_IDLE;

  // Per-port park state: parked flag, pause or idle, which pause
  logic [NP-1:0] park_q;
  logic [NP-1:0] pause_q;
  logic [NP-1:0] pdr_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      park_q  <= '1;
      pause_q <= '0;
      pdr_q   <= '0;
    end else if (rise && selected) begin
      for (int i = 0; i < NP; i++) begin
        if (!park_q[i] && pause_park_now) begin
          // Exit1 with mode-select high goes straight to Update
          park_q[i]  <= 1'b1;
          pause_q[i] <= 1'b1;
          pdr_q[i]   <= (state == lsppc_pkg::TAP_EX1_DR);
        end else if (!park_q[i] && idle_park_now) begin
          park_q[i]  <= 1'b1;
          pause_q[i] <= 1'b0;
        end else if (park_q[i] && pause_q[i] && unpark_op &&
                     nxt == (pdr_q[i] ? lsppc_pkg::TAP_PAU_DR
                                      : lsppc_pkg::TAP_PAU_IR)) begin
          park_q[i] <= 1'b0;
        end else if (park_q[i] && !pause_q[i] && port_en[i] &&
                     (instr_q == lsppc_pkg::OP_UNPARK ||
                      (state == lsppc_pkg::TAP_UPD_IR &&
                       ir_sh_q == lsppc_pkg::OP_UNPARK)) &&
                     nxt == lsppc_pkg::TAP_RTI) begin
          park_q[i] <= 1'b0;
        end
        // Anything else, including a new instruction, keeps the state
      end
    end
  end

  assign parked       = park_q;
  assign parked_pause = park_q & pause_q;

  // Local mode-select and clock; both taken from the same synchroniser
  // depth so the local TAPs see mode-select settled at their rising edge.
  logic [NP-1:0] ltms_q;
  logic          ltck_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ltms_q <= '0;
      ltck_q <= 1'b0;
    end else begin
      ltck_q <= st_q[B_TCK];
      for (int i = 0; i < NP; i++) begin
        if (park_q[i] || pause_park_now || idle_park_now) begin
          ltms_q[i] <= 1'b0;
        end else begin
          ltms_q[i] <= tms_st;
        end
      end
    end
  end

  assign ltms = ltms_q;
  assign ltck = ltck_q;

  // Scan path: own register first, then each unparked port in order
  logic [NP:0]   chain;
  logic [NP-1:0] ltdi_q;
  logic          tdo_q;
  logic          tdo_oe_n_q;

  assign chain[0] = lsppc_pkg::is_ir(state) ? ir_sh_q[0] : byp_q;

  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : g_chain
      assign chain[g+1] = park_q[g] ? chain[g] : ltdo_st[g];
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ltdi_q <= '0;
    end else begin
      ltdi_q <= chain[NP-1:0];
    end
  end

  // Broadcast-selected bridges never drive the shared return line
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tdo_q      <= 1'b1;
      tdo_oe_n_q <= 1'b1;
    end else if (fall) begin
      tdo_q      <= chain[NP];
      tdo_oe_n_q <= !(sel_q == lsppc_pkg::SEL_SINGLE &&
                      (state == lsppc_pkg::TAP_SH_IR ||
                       state == lsppc_pkg::TAP_SH_DR));
    end
  end

  assign ltdi          = ltdi_q;
  assign link.tdo      = tdo_q;
  assign link.tdo_oe_n = tdo_oe_n_q;
endmodule : lsppc_dev

// ===== lsppc_host.sv
// Controller end: plays one test clock period per accepted step.
// Assumes the user orders the steps; mode-select is overridden only where
// the park sequences require it.
`timescale 1ns/1ps
module lsppc_host (
  input  wire logic                  clk,
  input  wire logic                  nrst,
  lsppc_link_if.host                 link,
  input  wire logic                  step_valid,
  input  wire logic                  step_tms,
  input  wire logic                  step_tdi,
  output logic                       step_ready,
  output logic                       rsp_valid,
  output logic                       rsp_tdo,
  output lsppc_pkg::lsppc_tap_e      tap_state
);
  logic       busy_q;
  logic [2:0] cnt_q;
  logic       tck_q;
  logic       tms_q;
  logic       tdi_q;
  logic       rsp_valid_q;
  logic       rsp_tdo_q;
  logic [7:0] sh_q;
  logic       adv;
  logic       fin;
  logic       tms_eff;
  logic       d1_q;
  logic       d2_q;
  logic       d3_q;
  logic       dst_q;
  lsppc_pkg::lsppc_tap_e st;

  lsppc_tap u_tap (
    .clk   (clk),
    .nrst  (nrst),
    .adv   (adv),
    .tms   (tms_q),
    .state (st),
    .nxt   ()
  );

  assign adv = busy_q && cnt_q == lsppc_pkg::CNT_RISE;
  // Return bit is taken at the end of the step, not at the rise: the
  // bridge only turns its output round several cycles after the fall.
  assign fin = busy_q && cnt_q == lsppc_pkg::CNT_FALL;

  always_comb begin
    tms_eff = step_tms;
    if (st == lsppc_pkg::TAP_UPD_IR && sh_q == lsppc_pkg::OP_PARK_IDLE) begin
      tms_eff = 1'b0;
    end else if (st == lsppc_pkg::TAP_EX1_IR &&
                 sh_q == lsppc_pkg::OP_RET_WAIT) begin
      tms_eff = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      busy_q <= 1'b0;
      cnt_q  <= '0;
      tck_q  <= 1'b0;
      tms_q  <= 1'b1;
      tdi_q  <= 1'b0;
    end else if (!busy_q) begin
      if (step_valid) begin
        busy_q <= 1'b1;
        cnt_q  <= '0;
        tms_q  <= tms_eff;
        tdi_q  <= step_tdi;
      end
    end else begin
      cnt_q <= cnt_q + 3'h1;
      if (cnt_q == lsppc_pkg::CNT_RISE) begin
        tck_q <= 1'b1;
      end else if (cnt_q == lsppc_pkg::CNT_FALL) begin
        tck_q  <= 1'b0;
        busy_q <= 1'b0;
      end
    end
  end

  // Returned data through three stages, as it crosses from the pins
  always_ff @(posedge clk) begin
    if (!nrst) begin
      d1_q  <= 1'b1;
      d2_q  <= 1'b1;
      d3_q  <= 1'b1;
      dst_q <= 1'b1;
    end else begin
      d1_q  <= link.tdo_line;
      d2_q  <= d1_q;
      d3_q  <= d2_q;
      dst_q <= (d2_q == d3_q) ? d2_q : dst_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sh_q        <= '0;
      rsp_valid_q <= 1'b0;
      rsp_tdo_q   <= 1'b0;
    end else begin
      rsp_valid_q <= fin;
      if (fin) begin
        rsp_tdo_q <= (d2_q == d3_q) ? d2_q : dst_q;
      end
      if (adv) begin
        if (st == lsppc_pkg::TAP_SH_IR) begin
          sh_q <= {tdi_q, sh_q[7:1]};
        end
      end
    end
  end

  assign step_ready = !busy_q;
  assign rsp_valid  = rsp_valid_q;
  assign rsp_tdo    = rsp_tdo_q;
  assign tap_state  = st;
  assign link.tck   = tck_q;
  assign link.tms   = tms_q;
  assign link.tdi   = tdi_q;
endmodule : lsppc_host

// ===== lsppc_properties.sv
// Checks on the link pins and the bridge's local port outputs.
// Assumes one clk domain; instantiated beside the link interface.
`timescale 1ns/1ps
module lsppc_properties (
  input wire logic                  clk,
  input wire logic                  nrst,
  input wire logic                  tck,
  input wire logic                  tms,
  input wire logic                  tdi,
  input wire logic                  tdo_oe_n,
  input wire logic                  ltck,
  input wire logic [6:0]            ltms,
  input wire logic [6:0]            parked,
  input wire logic [6:0]            parked_pause,
  input lsppc_pkg::lsppc_sel_e      sel_state
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_ltck_rise: assert property ($rose(tck) |-> ##[1:7] ltck)
    else $error("local clock missed a rise");
  chk_ltck_fall: assert property ($fell(tck) |-> ##[1:7] !ltck)
    else $error("local clock missed a fall");
  chk_unparked_agree: assert property (
    ((ltms | parked) == 7'h7f) || ((ltms & ~parked) == 7'h00))
    else $error("unparked ports disagree on mode-select");
  chk_parked_held_low: assert property (
    (parked & $past(parked) & ltms) == 7'h00)
    else $error("parked port saw mode-select high");
  chk_pause_is_parked: assert property (
    (parked_pause & ~parked) == 7'h00)
    else $error("pause flag on an unparked port");
  chk_pause_kept: assert property (
    ($past(parked_pause) & ~parked_pause & parked) == 7'h00)
    else $error("pause park turned into idle park");
  chk_reset_values: assert property ($rose(nrst) |->
    parked == 7'h7f && parked_pause == 7'h00 &&
    sel_state == lsppc_pkg::SEL_WAIT)
    else $error("wrong state after reset");
  chk_sel_from_wait: assert property (
    $changed(sel_state) && sel_state != lsppc_pkg::SEL_WAIT |->
    $past(sel_state) == lsppc_pkg::SEL_WAIT)
    else $error("selection changed outside address wait");
  chk_drive_single: assert property (
    !tdo_oe_n |-> sel_state == lsppc_pkg::SEL_SINGLE)
    else $error("serial out driven while not singly selected");
  chk_host_hold: assert property (
    tck |-> $stable(tms) && $stable(tdi))
    else $error("host changed mode-select while clock high");

  cover property ($rose(parked_pause[0]));
  cover property ($fell(parked[0]));
  cover property (sel_state == lsppc_pkg::SEL_BCAST);
  cover property (sel_state == lsppc_pkg::SEL_UNSEL);
endmodule : lsppc_properties

// ===== lsppc_test.sv
// Self-checking bench: host and bridge ends joined by the link interface.
// Assumes the package, interface, design and checker compile first.
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  fails++; $display("BAD %s exp %h got %h", n, e, g); end end
module lsppc_test;
  logic                   clk = 1'b0;
  logic                   nrst = 1'b0;
  logic                   step_valid = 1'b0;
  logic                   step_tms = 1'b0;
  logic                   step_tdi = 1'b0;
  logic [7:0]             slot_addr = 8'h25;
  logic [6:0]             port_en = 7'h5b;
  logic                   tdo_bit = 1'b0;
  logic [7:0]             cap = 8'h00;
  int                     fails = 0;
  int                     check_count = 0;
  int                     cyc = 0;
  wire logic              step_ready, rsp_valid, rsp_tdo, ltck;
  wire logic [6:0]        ltms, ltdi, parked, parked_pause;
  wire logic [6:0]        ltdo = ltdi;
  lsppc_pkg::lsppc_sel_e  sel_state;
  lsppc_pkg::lsppc_tap_e  tap_state;

  always #50 clk = ~clk;

  lsppc_link_if link ();
  lsppc_host i_lsppc_host (.clk(clk), .nrst(nrst), .link(link.host),
    .step_valid(step_valid), .step_tms(step_tms), .step_tdi(step_tdi),
    .step_ready(step_ready), .rsp_valid(rsp_valid), .rsp_tdo(rsp_tdo),
    .tap_state(tap_state));
  lsppc_dev i_lsppc_dev (.clk(clk), .nrst(nrst), .link(link.dev),
    .slot_addr(slot_addr), .port_en(port_en), .ltdo(ltdo), .ltck(ltck),
    .ltms(ltms), .ltdi(ltdi), .parked(parked),
    .parked_pause(parked_pause), .sel_state(sel_state));
  lsppc_properties i_lsppc_properties (.clk(clk), .nrst(nrst),
    .tck(link.tck), .tms(link.tms), .tdi(link.tdi),
    .tdo_oe_n(link.tdo_oe_n), .ltck(ltck), .ltms(ltms), .parked(parked),
    .parked_pause(parked_pause), .sel_state(sel_state));

  task automatic conclude();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude

  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      conclude();
    end
  end

  task automatic settle();
    repeat (8) @(negedge clk);
  endtask : settle

  // One test clock period; the return bit is kept in tdo_bit
  task automatic step(input logic t, input logic d);
    int n;
    n = 0;
    while (!step_ready && n < 40) begin
      @(negedge clk);
      n++;
    end
    step_valid = 1'b1;
    step_tms = t;
    step_tdi = d;
    @(negedge clk);
    step_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    tdo_bit = rsp_tdo;
    if (n >= 20) fails++;
  endtask : step

  // From Run-Test/Idle: IR scan, optional pause, back to idle
  task automatic ir(input logic [7:0] op, input bit pz, input logic lt);
    step(1'b1, 1'b0);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    step(1'b0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      step(i == 7, op[i]);
      cap = {tdo_bit, cap[7:1]};
    end
    if (pz) begin
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
    end
    step(1'b1, 1'b0);
    step(lt, 1'b0);
    settle();
  endtask : ir

  // DR pass with no shift, optionally through Pause-DR
  task automatic dr(input bit pz);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    if (pz) begin
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
    end
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    settle();
  endtask : dr

  task automatic t_reset();
    nrst = 1'b0;
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    `CHK("sel", lsppc_pkg::SEL_WAIT, sel_state)
    `CHK("parked", 7'h7f, parked)
    `CHK("pause", 7'h00, parked_pause)
    step(1'b0, 1'b0);
  endtask : t_reset

  task automatic t_select_unpark();
    ir(slot_addr, 0, 1'b0);
    `CHK("released", 8'hff, cap)
    `CHK("sel", lsppc_pkg::SEL_SINGLE, sel_state)
    ir(lsppc_pkg::OP_UNPARK, 0, 1'b0);
    `CHK("ir only", lsppc_pkg::IR_CAPTURE, cap)
    `CHK("parked", 7'h24, parked)
    step(1'b1, 1'b0);
    settle();
    `CHK("follow", 7'h5b, ltms)
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    settle();
  endtask : t_select_unpark

  task automatic t_park_wait();
    ir(lsppc_pkg::OP_PARK_PAUSE, 0, 1'b0);
    `CHK("parked", 7'h7f, parked)
    `CHK("pause", 7'h5b, parked_pause)
    ir(lsppc_pkg::OP_RET_WAIT, 0, 1'b0);
    `CHK("ir only", lsppc_pkg::IR_CAPTURE, cap)
    `CHK("sel", lsppc_pkg::SEL_WAIT, sel_state)
    `CHK("pause", 7'h5b, parked_pause)
  endtask : t_park_wait

  task automatic t_unselected();
    ir(8'h11, 0, 1'b0);
    `CHK("sel", lsppc_pkg::SEL_UNSEL, sel_state)
    ir(lsppc_pkg::OP_UNPARK, 0, 1'b0);
    `CHK("released", 8'hff, cap)
    `CHK("parked", 7'h7f, parked)
    ir(lsppc_pkg::OP_RET_WAIT, 0, 1'b0);
    `CHK("sel", lsppc_pkg::SEL_WAIT, sel_state)
  endtask : t_unselected

  task automatic t_broadcast();
    ir(lsppc_pkg::ADDR_BCAST, 0, 1'b0);
    `CHK("sel", lsppc_pkg::SEL_BCAST, sel_state)
    ir(lsppc_pkg::OP_PARK_PAUSE, 1, 1'b0);
    `CHK("parked", 7'h24, parked)
    dr(1);
    `CHK("parked", 7'h24, parked)
    dr(0);
    `CHK("pause", 7'h5b, parked_pause)
    ir(lsppc_pkg::OP_RET_WAIT, 0, 1'b0);
    `CHK("pause", 7'h5b, parked_pause)
  endtask : t_broadcast

  task automatic t_readout();
    ir(slot_addr, 0, 1'b0);
    ir(lsppc_pkg::OP_BYPASS, 0, 1'b0);
    dr(1);
    `CHK("parked", 7'h7f, parked)
    ir(lsppc_pkg::OP_PARK_PAUSE, 0, 1'b0);
    `CHK("parked", 7'h7f, parked)
    dr(1);
    `CHK("parked", 7'h24, parked)
    `CHK("pause", 7'h00, parked_pause)
  endtask : t_readout

  // Last mode-select 1 is overridden by the host after the update; the
  // Pause-IR pass keeps the still active park-in-pause from parking first.
  task automatic t_park_idle();
    ir(lsppc_pkg::OP_PARK_IDLE, 1, 1'b1);
    `CHK("tap", lsppc_pkg::TAP_RTI, tap_state)
    `CHK("parked", 7'h7f, parked)
    `CHK("pause", 7'h00, parked_pause)
    `CHK("idle low", 7'h00, ltms)
  endtask : t_park_idle

  initial begin
    t_reset();
    t_select_unpark();
    t_park_wait();
    t_unselected();
    t_broadcast();
    t_readout();
    t_park_idle();
    t_reset();
    conclude();
  end
endmodule : lsppc_test
